// File: dv/dpt_timers_test.sv
module dpt_timers_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic        cyc_i  = 1'b0;
  logic        stb_i  = 1'b0;
  logic        we_i   = 1'b0;
  logic [7:0]  adr_i  = 8'h00;
  logic [3:0]  sel_i  = 4'h0;
  logic [31:0] dat_i  = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [6:0]  src    = 7'h00;
  logic [6:0]  src_run = 7'h00;
  logic [3:0]  en     = 4'h0;
  logic        ps     = 1'b0;
  logic        wave_a;
  logic        wave_b;
  logic        irq_o;
  logic        wake_o;
  logic [31:0] rdat;
  int          fail_count = 0;
  int          total_checks = 0;

  always #5 clk_i = ~clk_i;

  // source bits: fast, slow, vlp, cmp, pin0, pin4, touch
  always @(posedge clk_i) begin
    src <= src ^ src_run;
  end

  dpt_timers dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o),
    .fast_internal_osc_i(src[0]), .slow_internal_osc_i(src[1]),
    .very_low_power_osc_i(src[2]), .comparator_i(src[3]),
    .port_pin_zero_i(src[4]), .port_pin_four_i(src[5]),
    .touch_sense_osc_i(src[6]),
    .fast_osc_en_i(en[0]), .slow_osc_en_i(en[1]),
    .vlp_osc_en_i(en[2]), .touch_osc_en_i(en[3]),
    .power_save_i(ps),
    .timer_a_wave_o(wave_a), .timer_b_wave_o(wave_b),
    .irq_o(irq_o), .wake_o(wake_o)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    check("ack", {31'h0, ack_o}, 32'h1);
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic setup(input bit b, input logic [7:0] ctl, scl, bnd);
    logic [7:0] base;
    base = b ? dpt_pkg::OFF_B_CONTROL : dpt_pkg::OFF_A_CONTROL;
    bus(1'b1, base, 32'h0);
    bus(1'b1, base + 8'h08, 32'h0);
    bus(1'b1, base + 8'h04, {24'h0, scl});
    bus(1'b1, base + 8'h0c, {24'h0, bnd});
    bus(1'b1, base, {24'h0, ctl});
  endtask

  // skips to an edge of the wave, then times two half periods
  task automatic measure(input bit b, input int exp);
    logic last;
    int   h;
    last = b ? wave_b : wave_a;
    h = 0;
    while ((b ? wave_b : wave_a) === last && h < 3000) begin
      @(posedge clk_i);
      h++;
    end
    for (int k = 0; k < 2; k++) begin
      last = b ? wave_b : wave_a;
      h = 0;
      do begin
        @(posedge clk_i);
        h++;
      end while ((b ? wave_b : wave_a) === last && h < 3000);
      check("half period", h, exp);
    end
  endtask

  task automatic t_regs();
    for (int a = 0; a <= 8'h28; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      check("reset value", rdat, 32'h0);
    end
    check("wave after reset", {wave_b, wave_a, irq_o}, 32'h0);
    for (int a = 0; a < 8'h20; a += 4) begin
      bus(1'b1, a[7:0], 32'h0000_00a5);
      bus(1'b0, a[7:0], 32'h0);
      check("read back", rdat, 32'h0000_00a5);
      bus(1'b1, a[7:0], 32'h0);
    end
    bus(1'b1, 8'h28, 32'h0000_00ff);
    bus(1'b0, 8'h28, 32'h0);
    check("unmapped", rdat, 32'h0);
  endtask

  task automatic t_scale();
    // every prescale code, then the widest divider at bound zero
    for (int p = 0; p < 4; p++) begin
      setup(1'b0, 8'h10, {1'b0, p[1:0], 5'h01}, 8'h01);
      measure(1'b0, 2 * (4 ** p) * 2);
    end
    setup(1'b0, 8'h10, 8'h1f, 8'h00);
    measure(1'b0, 32);
    for (int x = 0; x < 4; x++) begin
      setup(1'b1, 8'h10, {6'h00, x[1:0]}, 8'h01);
      measure(1'b1, 2 * ((x == 0) ? 1 : (x == 1) ? 2 : 4));
    end
    setup(1'b1, 8'h10, 8'h21, 8'h01);
    measure(1'b1, 16);
  endtask

  task automatic t_sources();
    // all oscillators report running, so enables never gate a tick
    en <= 4'hf;
    // one toggling source at a time: a tick every second cycle
    for (int c = 2; c < 8; c++) begin
      src_run <= 7'h01 << (c - 2);
      setup(1'b0, {c[3:0], 4'h0}, 8'h00, 8'h01);
      measure(1'b0, 4);
    end
    setup(1'b0, 8'h00, 8'h00, 8'h00);
    for (int c = 2; c < 7; c++) begin
      src_run <= (c == 6) ? 7'h40 : 7'h01 << (c - 2);
      setup(1'b1, {1'b0, c[2:0], 4'h0}, 8'h00, 8'h01);
      measure(1'b1, 4);
    end
    // codes that select nothing leave the count alone
    src_run <= 7'h7f;
    setup(1'b0, 8'h80, 8'h00, 8'h01);
    setup(1'b1, 8'h70, 8'h00, 8'h01);
    repeat (20) @(posedge clk_i);
    bus(1'b0, dpt_pkg::OFF_A_COUNT, 32'h0);
    check("a dead code count", rdat, 32'h0);
    bus(1'b0, dpt_pkg::OFF_B_COUNT, 32'h0);
    check("b dead code count", rdat, 32'h0);
    src_run <= 7'h00;
    setup(1'b1, 8'h00, 8'h00, 8'h00);
    en <= 4'h0;
  endtask

  task automatic t_load_irq();
    int n;
    bus(1'b1, dpt_pkg::OFF_A_COUNT, 32'h37);
    bus(1'b0, dpt_pkg::OFF_A_COUNT, 32'h0);
    check("count load", rdat, 32'h37);
    bus(1'b1, dpt_pkg::OFF_A_BOUND, 32'h40);
    bus(1'b1, dpt_pkg::OFF_A_COUNT, 32'h3e);
    bus(1'b1, dpt_pkg::OFF_IRQ_STAT, 32'h3);
    bus(1'b1, dpt_pkg::OFF_IRQ_MASK, 32'h1);
    bus(1'b1, dpt_pkg::OFF_A_CONTROL, 32'h10);
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check("wrap from load", {31'h0, n <= 4}, 32'h1);
    bus(1'b1, dpt_pkg::OFF_A_CONTROL, 32'h0);
    bus(1'b1, dpt_pkg::OFF_IRQ_MASK, 32'h0);
    check("masked irq", {31'h0, irq_o}, 32'h0);
    bus(1'b0, dpt_pkg::OFF_IRQ_STAT, 32'h0);
    check("sticky status", rdat, 32'h1);
    bus(1'b1, dpt_pkg::OFF_IRQ_STAT, 32'h1);
    bus(1'b0, dpt_pkg::OFF_IRQ_STAT, 32'h0);
    check("status clear", rdat, 32'h0);
  endtask

  task automatic t_power();
    logic w;
    int   n;
    ps <= 1'b1;
    setup(1'b0, 8'h10, 8'h00, 8'h01);
    w = wave_a;
    repeat (40) @(posedge clk_i);
    check("sys halted", {31'h0, wave_a}, {31'h0, w});
    // an even number of toggles would hide a running timer: read the count
    bus(1'b0, dpt_pkg::OFF_A_COUNT, 32'h0);
    check("sys halted count", rdat, 32'h0);
    src_run <= 7'h01;
    setup(1'b0, 8'h20, 8'h00, 8'h01);
    w = wave_a;
    repeat (40) @(posedge clk_i);
    check("osc off halted", {31'h0, wave_a}, {31'h0, w});
    bus(1'b0, dpt_pkg::OFF_A_COUNT, 32'h0);
    check("osc off count", rdat, 32'h0);
    en <= 4'h1;
    n = 0;
    while (wake_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check("wake pulse", {31'h0, wake_o}, 32'h1);
    measure(1'b0, 4);
    ps <= 1'b0;
    src_run <= 7'h00;
  endtask

  // watchdog sized well above the expected run
  initial begin
    #800000;
    fail_count++;
    results();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_scale();
    t_sources();
    t_load_irq();
    t_power();
    results();
  end
endmodule

// File: hdl/dpt_chan.sv
module dpt_chan (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] pre_sel_i,
  input  wire logic [4:0] div_max_i,
  input  wire logic [7:0] bound_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  output logic      [7:0] count_o,
  output logic            wave_o,
  output logic            wrap_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [5:0] pre_cnt;
  logic [5:0] pre_max;
  logic [4:0] div_cnt;
  logic       pre_done;
  logic       step;

  // prescale terminal count
  always_comb begin
    case (pre_sel_i)
      2'h0:    pre_max = dpt_pkg::PRE_MAX1;
      2'h1:    pre_max = dpt_pkg::PRE_MAX4;
      2'h2:    pre_max = dpt_pkg::PRE_MAX16;
      default: pre_max = dpt_pkg::PRE_MAX64;
    endcase
  end

  // >= so a shrinking setting never strands the counter past its end
  assign pre_done = tick_i && (pre_cnt >= pre_max);
  assign step     = pre_done && (div_cnt >= div_max_i);
  assign wrap_o   = step && (count_o == bound_i) && !load_i;

  // prescaler
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 6'h00;
    end else if (tick_i) begin
      pre_cnt <= pre_done ? 6'h00 : pre_cnt + 6'h01;
    end
  end

  // second divider, terminal value is divisor minus one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 5'h00;
    end else if (pre_done) begin
      div_cnt <= (div_cnt >= div_max_i) ? 5'h00 : div_cnt + 5'h01;
    end
  end

  // main counter, software load wins over a step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= 8'h00;
    end else if (load_i) begin
      count_o <= load_data_i;
    end else if (step) begin
      if (count_o == bound_i) begin
        count_o <= 8'h00;
      end else begin
        count_o <= count_o + 8'h01;
      end
    end
  end

  // one toggle per wrap gives two equal halves
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_o <= 1'b0;
    end else if (wrap_o) begin
      wave_o <= ~wave_o;
    end
  end

  a_wrap_zero: assert property (wrap_o |=> count_o == 8'h00)
    else $error("counter not zero after wrap");
  a_wave_flip: assert property (wrap_o |=> wave_o != $past(wave_o))
    else $error("waveform did not invert on wrap");
  a_wave_hold: assert property (!wrap_o |=> $stable(wave_o))
    else $error("waveform moved without wrap");
  a_load_now: assert property (
    load_i |=> count_o == $past(load_data_i))
    else $error("count write not taken at once");
  a_count_step: assert property (
    step && !load_i && count_o != bound_i
    |=> count_o == $past(count_o) + 8'h01)
    else $error("counter did not advance by one");
  a_count_idle: assert property (
    !step && !load_i |=> $stable(count_o))
    else $error("counter moved without a divided tick");
endmodule

// File: hdl/dpt_pkg.sv
// Functional notes
// - timer a picks system, fast, slow, very low power, comparator or pins
// - timer a prescaler divides by 1, 4, 16 or 64 from scaler bits 6:5
// - timer a then divides by scaler bits 4:0 plus one
// - timer a counts up over 8 bits; count register loads and reads back
// - each counter returns to zero on the step after reaching its bound
// - period mode only: each wrap gives a waveform edge and an event
// - output waveform always has a 50 percent duty cycle
// - output rate is source over 2*(bound+1)*prescale*divide; timer a divide is (scaler+1)
// - both timers accept the very low power oscillator as count clock
// - timer b picks system, oscillators, comparator or touch oscillator
// - timer b prescaler divides by 1, 4, 16 or 64 from scaler bits 6:5
// - timer b extra divide by 1, 2 or 4 from scaler bits 1:0
// - timer b counts up over 8 bits; count register loads and reads
// - in power save a non-system-clocked timer wakes chip on wrap
// - in power save a timer halts on system clock or disabled oscillator
package dpt_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_A_CONTROL = 8'h00;
  localparam logic [7:0] OFF_A_SCALER  = 8'h04;
  localparam logic [7:0] OFF_A_COUNT   = 8'h08;
  localparam logic [7:0] OFF_A_BOUND   = 8'h0c;
  localparam logic [7:0] OFF_B_CONTROL = 8'h10;
  localparam logic [7:0] OFF_B_SCALER  = 8'h14;
  localparam logic [7:0] OFF_B_COUNT   = 8'h18;
  localparam logic [7:0] OFF_B_BOUND   = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h24;
  // field positions
  localparam int A_SEL_HI  = 7;
  localparam int A_SEL_LO  = 4;
  localparam int B_SEL_HI  = 6;
  localparam int B_SEL_LO  = 4;
  localparam int PRE_HI    = 6;
  localparam int PRE_LO    = 5;
  localparam int A_DIV_HI  = 4;
  localparam int B_DIV_HI  = 1;
  localparam int STAT_A    = 0;
  localparam int STAT_B    = 1;
  // reset values
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [1:0] RST_IRQ  = 2'h0;
  // clock source codes, timer a uses all four bits, timer b the low three
  localparam logic [3:0] SRC_STOP = 4'h0;
  localparam logic [3:0] SRC_SYS  = 4'h1;
  localparam logic [3:0] SRC_FAST = 4'h2;
  localparam logic [3:0] SRC_SLOW = 4'h3;
  localparam logic [3:0] SRC_VLP  = 4'h4;
  localparam logic [3:0] SRC_CMP  = 4'h5;
  localparam logic [3:0] SRC_PIN0 = 4'h6; // timer a only
  localparam logic [3:0] SRC_TCH  = 4'h6; // timer b only
  localparam logic [3:0] SRC_PIN4 = 4'h7; // timer a only
  // prescale terminal counts for /1 /4 /16 /64
  localparam logic [5:0] PRE_MAX1  = 6'h00;
  localparam logic [5:0] PRE_MAX4  = 6'h03;
  localparam logic [5:0] PRE_MAX16 = 6'h0f;
  localparam logic [5:0] PRE_MAX64 = 6'h3f;
  // number of external clock-like inputs watched for edges
  localparam int N_RAW = 7;
endpackage

// File: hdl/dpt_timers.sv
module dpt_timers (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // clock sources, sampled as levels
  input  wire logic        fast_internal_osc_i,
  input  wire logic        slow_internal_osc_i,
  input  wire logic        very_low_power_osc_i,
  input  wire logic        comparator_i,
  input  wire logic        port_pin_zero_i,
  input  wire logic        port_pin_four_i,
  input  wire logic        touch_sense_osc_i,
  // oscillator enables and chip power state
  input  wire logic        fast_osc_en_i,
  input  wire logic        slow_osc_en_i,
  input  wire logic        vlp_osc_en_i,
  input  wire logic        touch_osc_en_i,
  input  wire logic        power_save_i,
  // results
  output logic             timer_a_wave_o,
  output logic             timer_b_wave_o,
  output logic             irq_o,
  output logic             wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0]  timer_a_control;
  logic [7:0]  timer_a_scaler;
  logic [7:0]  timer_a_bound;
  logic [7:0]  timer_b_control;
  logic [7:0]  timer_b_scaler;
  logic [7:0]  timer_b_bound;
  logic [7:0]  timer_a_count;
  logic [7:0]  timer_b_count;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [1:0]  next_irq_status;

  logic [dpt_pkg::N_RAW-1:0] raw;
  logic [dpt_pkg::N_RAW-1:0] raw_q;
  logic [dpt_pkg::N_RAW-1:0] raw_edge;
  logic [7:0]  src_a;
  logic [7:0]  src_b;
  logic [7:0]  en_a;
  logic [7:0]  en_b;
  logic [3:0]  sel_a;
  logic [3:0]  sel_b;
  logic        halt_a;
  logic        halt_b;
  logic        tick_a;
  logic        tick_b;
  logic [4:0]  div_max_b;
  logic        wrap_a;
  logic        wrap_b;

  logic        req;
  logic        wr;
  logic        load_a;
  logic        load_b;
  logic [7:0]  rd_data;

  // bus decode; a request is served in the cycle it first appears
  assign req    = cyc_i && stb_i && !ack_o;
  assign wr     = req && we_i && sel_i[0];
  assign load_a = wr && (adr_i == dpt_pkg::OFF_A_COUNT);
  assign load_b = wr && (adr_i == dpt_pkg::OFF_B_COUNT);

  // ack for one cycle, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // timer a source select; unmapped writes fall through unnoticed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_control <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_A_CONTROL) begin
      timer_a_control <= dat_i[7:0];
    end
  end

  // timer a prescale and divider settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_scaler <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_A_SCALER) begin
      timer_a_scaler <= dat_i[7:0];
    end
  end

  // timer a bound; a new bound meets the very next compare
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_bound <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_A_BOUND) begin
      timer_a_bound <= dat_i[7:0];
    end
  end

  // timer b source select, bit 7 is kept but unused
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_b_control <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_B_CONTROL) begin
      timer_b_control <= dat_i[7:0];
    end
  end

  // timer b prescale and extra divide settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_b_scaler <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_B_SCALER) begin
      timer_b_scaler <= dat_i[7:0];
    end
  end

  // timer b bound
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_b_bound <= dpt_pkg::RST_REG;
    end else if (wr && adr_i == dpt_pkg::OFF_B_BOUND) begin
      timer_b_bound <= dat_i[7:0];
    end
  end

  // interrupt mask, only the two flag bits exist
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= dpt_pkg::RST_IRQ;
    end else if (wr && adr_i == dpt_pkg::OFF_IRQ_MASK) begin
      irq_mask <= dat_i[1:0];
    end
  end

  // read mux, holes and the irq bits above the two flags read zero
  always_comb begin
    rd_data = 8'h00;
    case (adr_i)
      dpt_pkg::OFF_A_CONTROL: rd_data = timer_a_control;
      dpt_pkg::OFF_A_SCALER:  rd_data = timer_a_scaler;
      dpt_pkg::OFF_A_COUNT:   rd_data = timer_a_count;
      dpt_pkg::OFF_A_BOUND:   rd_data = timer_a_bound;
      dpt_pkg::OFF_B_CONTROL: rd_data = timer_b_control;
      dpt_pkg::OFF_B_SCALER:  rd_data = timer_b_scaler;
      dpt_pkg::OFF_B_COUNT:   rd_data = timer_b_count;
      dpt_pkg::OFF_B_BOUND:   rd_data = timer_b_bound;
      dpt_pkg::OFF_IRQ_STAT:  rd_data = {6'h00, irq_status};
      dpt_pkg::OFF_IRQ_MASK:  rd_data = {6'h00, irq_mask};
      default:                rd_data = 8'h00;
    endcase
  end

  // read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req) begin
      dat_o <= {24'h00_0000, rd_data};
    end
  end

  // rising-edge detect on every clock-like input
  assign raw = {touch_sense_osc_i, port_pin_four_i, port_pin_zero_i,
                comparator_i, very_low_power_osc_i, slow_internal_osc_i,
                fast_internal_osc_i};
  genvar gi;
  generate
    for (gi = 0; gi < dpt_pkg::N_RAW; gi++) begin : g_edge
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          raw_q[gi] <= 1'b0;
        end else begin
          raw_q[gi] <= raw[gi];
        end
      end
      assign raw_edge[gi] = raw[gi] && !raw_q[gi];
    end
  endgenerate

  // source tables indexed by the select code; the system clock ticks always
  assign src_a = {raw_edge[5], raw_edge[4], raw_edge[3], raw_edge[2],
                  raw_edge[1], raw_edge[0], 1'b1, 1'b0};
  assign src_b = {1'b0, raw_edge[6], raw_edge[3], raw_edge[2],
                  raw_edge[1], raw_edge[0], 1'b1, 1'b0};
  assign en_a  = {1'b1, 1'b1, 1'b1, vlp_osc_en_i, slow_osc_en_i,
                  fast_osc_en_i, 1'b1, 1'b0};
  assign en_b  = {1'b0, touch_osc_en_i, 1'b1, vlp_osc_en_i, slow_osc_en_i,
                  fast_osc_en_i, 1'b1, 1'b0};

  assign sel_a = timer_a_control[dpt_pkg::A_SEL_HI:dpt_pkg::A_SEL_LO];
  assign sel_b = {1'b0, timer_b_control[dpt_pkg::B_SEL_HI:dpt_pkg::B_SEL_LO]};

  // power save halts a timer on system clock or on a dead oscillator
  assign halt_a = power_save_i &&
                  (sel_a == dpt_pkg::SRC_SYS || !en_a[sel_a[2:0]]);
  assign halt_b = power_save_i &&
                  (sel_b == dpt_pkg::SRC_SYS || !en_b[sel_b[2:0]]);
  // codes 8..15 of timer a select nothing
  assign tick_a = !sel_a[3] && src_a[sel_a[2:0]] && !halt_a;
  assign tick_b = src_b[sel_b[2:0]] && !halt_b;

  // timer b extra divide; code 3 is treated as /4
  always_comb begin
    case (timer_b_scaler[dpt_pkg::B_DIV_HI:0])
      2'h0:    div_max_b = 5'h00;
      2'h1:    div_max_b = 5'h01;
      default: div_max_b = 5'h03;
    endcase
  end

  dpt_chan u_chan_a (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tick_i      (tick_a),
    .pre_sel_i   (timer_a_scaler[dpt_pkg::PRE_HI:dpt_pkg::PRE_LO]),
    .div_max_i   (timer_a_scaler[dpt_pkg::A_DIV_HI:0]),
    .bound_i     (timer_a_bound),
    .load_i      (load_a),
    .load_data_i (dat_i[7:0]),
    .count_o     (timer_a_count),
    .wave_o      (timer_a_wave_o),
    .wrap_o      (wrap_a)
  );

  dpt_chan u_chan_b (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tick_i      (tick_b),
    .pre_sel_i   (timer_b_scaler[dpt_pkg::PRE_HI:dpt_pkg::PRE_LO]),
    .div_max_i   (div_max_b),
    .bound_i     (timer_b_bound),
    .load_i      (load_b),
    .load_data_i (dat_i[7:0]),
    .count_o     (timer_b_count),
    .wave_o      (timer_b_wave_o),
    .wrap_o      (wrap_b)
  );

  // sticky flags, write one to clear; a wrap in the clearing cycle wins
  always_comb begin
    next_irq_status = irq_status;
    if (wr && adr_i == dpt_pkg::OFF_IRQ_STAT) begin
      next_irq_status = irq_status & ~dat_i[1:0];
    end
    next_irq_status[dpt_pkg::STAT_A] =
      next_irq_status[dpt_pkg::STAT_A] | wrap_a;
    next_irq_status[dpt_pkg::STAT_B] =
      next_irq_status[dpt_pkg::STAT_B] | wrap_b;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= dpt_pkg::RST_IRQ;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // wake pulse only for timers not on the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= power_save_i &&
                ((wrap_a && sel_a != dpt_pkg::SRC_SYS) ||
                 (wrap_b && sel_b != dpt_pkg::SRC_SYS));
    end
  end

  sequence s_req_seen;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ack_once;
    ack_o ##1 !ack_o;
  endsequence

  a_bus_ack_once: assert property (s_req_seen |=> s_ack_once)
    else $error("bus ack not a single cycle answer");
  a_wrap_flag_set: assert property (wrap_a |=> irq_status[0])
    else $error("timer a wrap did not set its flag");
  a_flag_sticky: assert property (
    irq_status[1] && !(wr && adr_i == dpt_pkg::OFF_IRQ_STAT && dat_i[1])
    |=> irq_status[1])
    else $error("timer b flag dropped without a clear");
  a_wake_cause: assert property (
    wake_o |-> $past(power_save_i) && $past(wrap_a || wrap_b))
    else $error("wake without wrap in power save");
  a_sys_halt_a: assert property (
    power_save_i && sel_a == dpt_pkg::SRC_SYS |-> !tick_a)
    else $error("timer a ticked on system clock in power save");
  a_vlp_tick_b: assert property (
    sel_b == dpt_pkg::SRC_VLP && vlp_osc_en_i && raw_edge[2] |-> tick_b)
    else $error("timer b missed a very low power edge");

  // register write and count read paths
  sequence s_bound_a_wr;
    wr && adr_i == dpt_pkg::OFF_A_BOUND;
  endsequence
  sequence s_rd_count_a;
    req && !we_i && adr_i == dpt_pkg::OFF_A_COUNT;
  endsequence
  sequence s_rd_count_b;
    req && !we_i && adr_i == dpt_pkg::OFF_B_COUNT;
  endsequence

  a_bound_write: assert property (s_bound_a_wr |=>
    timer_a_bound == $past(dat_i[7:0]))
    else $error("timer a bound write lost");
  a_rd_count_a: assert property (s_rd_count_a |=>
    ack_o && dat_o[7:0] == $past(timer_a_count))
    else $error("timer a count read back wrong");
  a_rd_count_b: assert property (s_rd_count_b |=>
    ack_o && dat_o[7:0] == $past(timer_b_count))
    else $error("timer b count read back wrong");
  a_clear_flag: assert property (
    wr && adr_i == dpt_pkg::OFF_IRQ_STAT && dat_i[dpt_pkg::STAT_A] && !wrap_a
    |=> !irq_status[dpt_pkg::STAT_A])
    else $error("timer a flag not cleared by a one");

  // dead codes never tick; timer b code 7 is all ones in its field
  a_stop_a: assert property (
    sel_a == dpt_pkg::SRC_STOP || sel_a[3] |-> !tick_a)
    else $error("timer a ticked on a dead source code");
  a_stop_b: assert property (
    sel_b == dpt_pkg::SRC_STOP || &sel_b[2:0] |-> !tick_b)
    else $error("timer b ticked on a dead source code");
  a_sys_tick_a: assert property (
    !power_save_i && sel_a == dpt_pkg::SRC_SYS |-> tick_a)
    else $error("timer a missed a system clock tick");
  a_vlp_tick_a: assert property (
    sel_a == dpt_pkg::SRC_VLP && vlp_osc_en_i && raw_edge[2] |-> tick_a)
    else $error("timer a missed a very low power edge");
  a_awake_quiet: assert property (!power_save_i |=> !wake_o)
    else $error("wake pulse outside power save");
endmodule
